// >>> pkg/gts_pkg.sv
// Constants, register map and field layouts of the gated timer.
// Assumes a 32-bit classic Wishbone slave port and a 100 MHz system clock.
package gts_pkg;

    // Register byte offsets
    localparam logic [7:0] CTRL_OFFSET     = 8'h00;
    localparam logic [7:0] STATUS_OFFSET   = 8'h04;
    localparam logic [7:0] PRELOAD1_OFFSET = 8'h08;
    localparam logic [7:0] COMPARE_OFFSET  = 8'h0C;
    localparam logic [7:0] SHADOW_OFFSET   = 8'h10;

    // Reset values, zero count and step sizes
    localparam logic [7:0]  PRESCALE_RESET = 8'hFF;
    localparam logic [15:0] COUNT_RESET    = 16'h0000;
    localparam logic [15:0] COUNT_ZERO     = 16'h0000;
    localparam logic [15:0] COUNT_STEP     = 16'h0001;
    localparam logic [7:0]  PRESCALE_STEP  = 8'h01;

    // Operating modes
    localparam logic [2:0] MODE_CAPTURE = 3'h0;
    localparam logic [2:0] MODE_SQUARE  = 3'h1;

    // Output control encodings
    localparam logic [1:0] OC_HOLD   = 2'h0;
    localparam logic [1:0] OC_TOGGLE = 2'h1;
    localparam logic [1:0] OC_ZERO   = 2'h2;
    localparam logic [1:0] OC_ONE    = 2'h3;

    localparam logic [2:0] IRQ_SEL_NONE = 3'h0;
    localparam logic [2:0] IRQ_SEL_STEP = 3'h1;
    localparam logic [6:0] IRQ_ONE      = 7'h01;

    // Control register layout
    typedef struct packed {
        logic [11:0] reserved;
        logic [2:0]  presc_tap;
        logic [2:0]  irq_sel;
        logic        ie_compare;
        logic        ie_gate;
        logic        ie_timeout;
        logic        init_level;
        logic [1:0]  output_control_field;
        logic [2:0]  mode;
        logic        presc_use;
        logic        ext_clk_sel;
        logic        gate_enable_bit;
        logic        count_prescale_enable;
        logic        soft_run_bit;
    } gts_ctrl_type;

    // Status register layout
    typedef struct packed {
        logic [24:0] reserved;
        logic        gate_level_flag;
        logic        out_level;
        logic        running;
        logic        compare_match;
        logic        compare_event_flag;
        logic        gate_event_flag;
        logic        timeout_flag;
    } gts_status_type;

    localparam logic [31:0] CTRL_WMASK = 32'h000FFFFF;

endpackage : gts_pkg

// >>> hdl/gts_timer.sv
// Gated timer with prescaler, 16-bit down counter, compare and shadow.
// Assumes a classic Wishbone master and pins synchronous only after sync.
`timescale 1ns/100ps

module gts_timer (
    // System
    input  wire logic        clk,
    input  wire logic        rst,
    // Wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // Timer pins
    input  wire logic        ext_clock_in,
    input  wire logic        gate_in_n,
    output logic             wave_out,
    // Interrupt request lines, bit k carries line k+1
    output logic      [6:0]  irq_line
);

    gts_pkg::gts_ctrl_type   control_reg;
    gts_pkg::gts_status_type status_reg;
    logic [15:0] preload_one_reg;
    logic [15:0] compare_reg;
    logic [15:0] count_shadow_reg;
    logic [15:0] count_reg;
    logic [7:0]  presc_reg;
    logic        ack_reg;
    logic [31:0] rdata_reg;
    logic        tin_meta_reg;
    logic        tin_sync_reg;
    logic        gate_meta_reg;
    logic        gate_sync_reg;
    logic        gate_prev_reg;
    logic        half_clk_reg;
    logic        sel_prev_reg;
    logic        tap_prev_reg;
    logic        started_reg;
    logic        tick_d_reg;
    logic        wave_reg;
    logic        timeout_reg;
    logic        gate_evt_reg;
    logic        cmp_evt_reg;
    logic        match_reg;
    logic [6:0]  irq_reg;

    logic        req;
    logic        wr_stb;
    logic [31:0] bmask;
    logic        sel_lvl;
    logic        sel_fall;
    logic        tap_lvl;
    logic        cnt_tick;
    logic        is_capture;
    logic        is_square;
    logic        run_req;
    logic        enabled;
    logic        gate_neg_edge;
    logic        gate_evt_set;
    logic        step;
    logic [15:0] count_next;
    logic        hit_timeout;
    logic        hit_compare;
    logic        any_irq;
    logic [31:0] status_w1c;

    // Bus decode: one-cycle ack; writes land at the edge that raises ack
    assign req    = wb_cyc_i && wb_stb_i && !ack_reg;
    assign wr_stb = req && wb_we_i;
    assign bmask  = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    assign status_w1c = (wr_stb && wb_adr_i == gts_pkg::STATUS_OFFSET) ? (wb_dat_i & bmask)
                                                                       : 32'h00000000;

    always_ff @(posedge clk) begin
        if (rst) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= req;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            rdata_reg <= 32'h00000000;
        end else if (req && !wb_we_i) begin
            if (wb_adr_i == gts_pkg::CTRL_OFFSET) begin
                rdata_reg <= control_reg;
            end else if (wb_adr_i == gts_pkg::STATUS_OFFSET) begin
                rdata_reg <= status_reg;
            end else if (wb_adr_i == gts_pkg::PRELOAD1_OFFSET) begin
                rdata_reg <= {16'h0000, preload_one_reg};
            end else if (wb_adr_i == gts_pkg::COMPARE_OFFSET) begin
                rdata_reg <= {16'h0000, compare_reg};
            end else if (wb_adr_i == gts_pkg::SHADOW_OFFSET) begin
                rdata_reg <= {16'h0000, count_shadow_reg};
            end else begin
                rdata_reg <= 32'h00000000;
            end
        end
    end

    assign wb_ack_o = ack_reg;
    assign wb_dat_o = rdata_reg;

    // Software-written registers; byte lanes honoured
    always_ff @(posedge clk) begin
        if (rst) begin
            control_reg     <= '0;
            preload_one_reg <= 16'h0000;
            compare_reg     <= 16'h0000;
        end else if (wr_stb) begin
            if (wb_adr_i == gts_pkg::CTRL_OFFSET) begin
                control_reg <= (control_reg & ~(bmask & gts_pkg::CTRL_WMASK))
                             | (wb_dat_i & bmask & gts_pkg::CTRL_WMASK);
            end else if (wb_adr_i == gts_pkg::PRELOAD1_OFFSET) begin
                preload_one_reg <= (preload_one_reg & ~bmask[15:0]) | (wb_dat_i[15:0] & bmask[15:0]);
            end else if (wb_adr_i == gts_pkg::COMPARE_OFFSET) begin
                compare_reg <= (compare_reg & ~bmask[15:0]) | (wb_dat_i[15:0] & bmask[15:0]);
            end
        end
    end

    // Pin synchronisers; first stages feed only the second stages
    always_ff @(posedge clk) begin
        if (rst) begin
            tin_meta_reg  <= 1'b0;
            tin_sync_reg  <= 1'b0;
            gate_meta_reg <= 1'b1;
            gate_sync_reg <= 1'b1;
            gate_prev_reg <= 1'b1;
        end else begin
            tin_meta_reg  <= ext_clock_in;
            tin_sync_reg  <= tin_meta_reg;
            gate_meta_reg <= gate_in_n;
            gate_sync_reg <= gate_meta_reg;
            gate_prev_reg <= gate_sync_reg;
        end
    end

    // Clock selection and falling-edge detection
    assign is_capture = control_reg.mode == gts_pkg::MODE_CAPTURE;
    assign is_square  = control_reg.mode == gts_pkg::MODE_SQUARE;
    assign sel_lvl    = control_reg.ext_clk_sel ? tin_sync_reg : half_clk_reg;
    assign sel_fall   = sel_prev_reg && !sel_lvl;
    assign tap_lvl    = presc_reg[control_reg.presc_tap];
    assign run_req    = control_reg.soft_run_bit && control_reg.count_prescale_enable;
    // Gate only pauses counting in square mode; capture mode uses it for shadow control
    assign enabled    = run_req && !(is_square && control_reg.gate_enable_bit && gate_sync_reg);
    assign cnt_tick   = enabled && (control_reg.presc_use ? (tap_prev_reg && !tap_lvl)
                                                          : sel_fall);
    assign gate_neg_edge = gate_sync_reg && !gate_prev_reg;

    always_ff @(posedge clk) begin
        if (rst) begin
            half_clk_reg <= 1'b0;
            sel_prev_reg <= 1'b0;
            tap_prev_reg <= 1'b1;
        end else begin
            half_clk_reg <= !half_clk_reg;
            sel_prev_reg <= sel_lvl;
            tap_prev_reg <= tap_lvl;
        end
    end

    // Prescaler steps on selected-clock falling edges while enabled
    always_ff @(posedge clk) begin
        if (rst) begin
            presc_reg <= gts_pkg::PRESCALE_RESET;
        end else if (enabled && sel_fall) begin
            presc_reg <= presc_reg - gts_pkg::PRESCALE_STEP;
        end
    end

    // Counter: load on first tick after enable and on the tick after timeout
    assign step       = cnt_tick && started_reg && count_reg != gts_pkg::COUNT_ZERO;
    assign count_next = count_reg - gts_pkg::COUNT_STEP;
    assign hit_timeout = step && count_next == gts_pkg::COUNT_ZERO;
    // Compare sampled at the decrement; a compare write in the same edge is not seen
    assign hit_compare = step && count_next == compare_reg;

    always_ff @(posedge clk) begin
        if (rst) begin
            count_reg   <= gts_pkg::COUNT_RESET;
            started_reg <= 1'b0;
        end else if (!run_req) begin
            started_reg <= 1'b0;
        end else if (cnt_tick) begin
            if (!started_reg || count_reg == gts_pkg::COUNT_ZERO) begin
                // Preload taken at this edge; a write landing now is seen next reload
                count_reg   <= preload_one_reg;
                started_reg <= 1'b1;
            end else begin
                count_reg <= count_next;
            end
        end
    end

    // Shadow follows the counter one cycle behind unless frozen by the gate flag
    always_ff @(posedge clk) begin
        if (rst) begin
            tick_d_reg       <= 1'b0;
            count_shadow_reg <= gts_pkg::COUNT_RESET;
        end else begin
            tick_d_reg <= cnt_tick;
            if (tick_d_reg && !gate_evt_reg) begin
                count_shadow_reg <= count_reg;
            end
        end
    end

    // Gate event: capture edge in capture mode, pause in square mode
    assign gate_evt_set = control_reg.gate_enable_bit && gate_neg_edge
                          && (is_capture || (is_square && run_req));

    // Sticky flags; a hardware set in the clearing cycle wins
    always_ff @(posedge clk) begin
        if (rst) begin
            timeout_reg  <= 1'b0;
            gate_evt_reg <= 1'b0;
            cmp_evt_reg  <= 1'b0;
        end else begin
            timeout_reg  <= (timeout_reg && !status_w1c[0]) || hit_timeout;
            gate_evt_reg <= (gate_evt_reg && !status_w1c[1]) || gate_evt_set;
            cmp_evt_reg  <= (cmp_evt_reg && !status_w1c[2]) || hit_compare;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            match_reg <= 1'b0;
        end else if (hit_timeout) begin
            match_reg <= 1'b0;
        end else if (hit_compare) begin
            match_reg <= 1'b1;
        end
    end

    // Waveform output: initial level while stopped, then events drive it
    always_ff @(posedge clk) begin
        if (rst) begin
            wave_reg <= 1'b0;
        end else if (!control_reg.soft_run_bit) begin
            wave_reg <= control_reg.init_level;
        end else if ((is_capture && hit_compare) || (is_square && hit_timeout)) begin
            case (control_reg.output_control_field)
                gts_pkg::OC_TOGGLE: wave_reg <= !wave_reg;
                gts_pkg::OC_ZERO:   wave_reg <= 1'b0;
                gts_pkg::OC_ONE:    wave_reg <= 1'b1;
                default:            wave_reg <= wave_reg;
            endcase
        end else if (is_capture && hit_timeout) begin
            // Forced levels return at timeout so compare sets a pulse width
            case (control_reg.output_control_field)
                gts_pkg::OC_ZERO: wave_reg <= 1'b1;
                gts_pkg::OC_ONE:  wave_reg <= 1'b0;
                default:          wave_reg <= wave_reg;
            endcase
        end
    end

    assign wave_out = wave_reg;

    always_comb begin
        status_reg                    = '0;
        status_reg.timeout_flag       = timeout_reg;
        status_reg.gate_event_flag    = gate_evt_reg;
        status_reg.compare_event_flag = cmp_evt_reg;
        status_reg.compare_match      = match_reg;
        status_reg.running            = enabled;
        status_reg.out_level          = wave_reg;
        status_reg.gate_level_flag    = !gate_sync_reg;
    end

    // Interrupt routing to the selected line
    assign any_irq = (timeout_reg && control_reg.ie_timeout)
                   || (gate_evt_reg && control_reg.ie_gate)
                   || (cmp_evt_reg && control_reg.ie_compare);

    always_ff @(posedge clk) begin
        if (rst) begin
            irq_reg <= 7'h00;
        end else if (any_irq && control_reg.irq_sel != gts_pkg::IRQ_SEL_NONE) begin
            irq_reg <= gts_pkg::IRQ_ONE << (control_reg.irq_sel - gts_pkg::IRQ_SEL_STEP);
        end else begin
            irq_reg <= 7'h00;
        end
    end

    assign irq_line = irq_reg;

endmodule : gts_timer

// >>> dv/gts_timer_checker.sv
// Port-level assertions for the gated timer.
// Assumes one clock domain and a synchronous, active-high reset.
`timescale 1ns/100ps
module gts_timer_checker (
    // System
    input wire logic        clk,
    input wire logic        rst,
    // Wishbone slave
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [7:0]  wb_adr_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    // Timer pins
    input wire logic        ext_clock_in,
    input wire logic        gate_in_n,
    input wire logic        wave_out,
    input wire logic [6:0]  irq_line
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence take_s;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence ctrl_wr_s;
        take_s ##0 (wb_we_i && wb_adr_i == gts_pkg::CTRL_OFFSET && wb_sel_i == 4'hF);
    endsequence

    ack_answer_a: assert property (take_s |=> wb_ack_o)
        else $error("ack missing one cycle after request");
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without request");
    unmapped_read_a: assert property (take_s ##0 (!wb_we_i && wb_adr_i == 8'h14)
        |=> wb_dat_o == 32'h0) else $error("unmapped read not zero");
    status_resv_a: assert property (take_s ##0 (!wb_we_i && wb_adr_i == gts_pkg::STATUS_OFFSET)
        |=> wb_dat_o[31:7] == 25'h0) else $error("status reserved bits set");
    irq_single_a: assert property ($onehot0(irq_line))
        else $error("more than one interrupt line");
    irq_mask_a: assert property (ctrl_wr_s ##0 (wb_dat_i[16:14] == 3'h0)
        |=> ##1 irq_line == 7'h00) else $error("interrupt with no line selected");
    idle_level_a: assert property (ctrl_wr_s ##0 (!wb_dat_i[0] && wb_dat_i[10])
        |=> ##[0:1] wave_out) else $error("output not at initial level");
    reset_clear_a: assert property ($fell(rst) |->
        !wb_ack_o && irq_line == 7'h00 && !wave_out) else $error("outputs not cleared");
endmodule : gts_timer_checker

bind gts_timer gts_timer_checker u_chk (.clk(clk), .rst(rst), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .ext_clock_in(ext_clock_in), .gate_in_n(gate_in_n), .wave_out(wave_out),
    .irq_line(irq_line));

// >>> dv/gts_pin_model.sv
// Model of the board side of the timer pins: external clock and gate.
// Assumes the bench changes its controls just after a rising clock edge.
`timescale 1ns/100ps
module gts_pin_model (
    // System
    input  wire logic clk,
    // Bench controls
    input  wire logic run_clk,
    input  wire logic gate_on,
    // Timer pins
    output logic      ext_clock_in,
    output logic      gate_in_n
);
    logic [1:0] div_reg = 2'h0;
    logic       ext_reg = 1'b1;

    // Each level lasts three system clocks, above the sync minimum
    always_ff @(posedge clk) begin
        if (run_clk) begin
            div_reg <= (div_reg == 2'h2) ? 2'h0 : div_reg + 2'h1;
            if (div_reg == 2'h2) begin
                ext_reg <= ~ext_reg;
            end
        end
    end
    assign ext_clock_in = ext_reg;
    // Gate moves only on bench commands, held for many cycles
    assign gate_in_n = ~gate_on;
endmodule : gts_pin_model

// >>> dv/testbench.sv
// Self-checking bench for the gated timer over classic Wishbone.
// Assumes the pin model drives the external clock and gate pins.
`timescale 1ns/100ps
module testbench;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        cyc = 1'b0;
    logic        stb = 1'b0;
    logic        we = 1'b0;
    logic [7:0]  adr = 8'h00;
    logic [3:0]  sel = 4'hF;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat;
    logic        ack;
    logic        ext_clk;
    logic        gate_n;
    logic        run_clk = 1'b0;
    logic        gate_on = 1'b1;
    logic        wave;
    logic [6:0]  irq;
    logic [31:0] q;
    logic [31:0] q2;
    int          gap;
    int          miscompares = 0;
    int          n_tests = 0;

    always #5 clk = ~clk;

    gts_timer uut (.clk(clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .ext_clock_in(ext_clk), .gate_in_n(gate_n), .wave_out(wave), .irq_line(irq));
    gts_pin_model pins (.clk(clk), .run_clk(run_clk), .gate_on(gate_on),
        .ext_clock_in(ext_clk), .gate_in_n(gate_n));

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 20);
        q = rdat;
        if (n >= 20) miscompares++;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask : xfer

    task automatic idle(input int n);
        repeat (n) @(posedge clk);
    endtask : idle

    // Cycles until the next change of the wave output
    task automatic edge_gap();
        logic w;
        w = wave;
        gap = 0;
        do begin
            @(posedge clk);
            gap++;
        end while (wave === w && gap < 100);
    endtask : edge_gap

    task automatic reset_scn();
        xfer(gts_pkg::CTRL_OFFSET, 1'b0, 32'h0);
        check(q, 32'h0);
        xfer(gts_pkg::STATUS_OFFSET, 1'b0, 32'h0);
        check(q, 32'h40);
        xfer(gts_pkg::SHADOW_OFFSET, 1'b0, 32'h0);
        check(q, 32'h0);
        xfer(8'h14, 1'b0, 32'h0);
        check(q, 32'h0);
        xfer(gts_pkg::CTRL_OFFSET, 1'b1, 32'hFFFFFFFE);
        xfer(gts_pkg::CTRL_OFFSET, 1'b0, 32'h0);
        check(q, 32'hFFFFFFFE & gts_pkg::CTRL_WMASK);
        check(wave, 1'b1);
        xfer(gts_pkg::CTRL_OFFSET, 1'b1, 32'h0);
        xfer(gts_pkg::SHADOW_OFFSET, 1'b1, 32'h1234);
        xfer(gts_pkg::SHADOW_OFFSET, 1'b0, 32'h0);
        check(q, 32'h0);
    endtask : reset_scn

    // Toggle on time-out, N = 3, timeout interrupt on line 2
    task automatic square_scn(input logic ext, input int per);
        logic [31:0] c;
        c = 32'h8922 | {28'h0, ext, 3'h0};
        run_clk <= ext;
        // Preload and control change only while stopped
        xfer(gts_pkg::PRELOAD1_OFFSET, 1'b1, 32'h3);
        xfer(gts_pkg::CTRL_OFFSET, 1'b1, c);
        xfer(gts_pkg::CTRL_OFFSET, 1'b1, c | 32'h1);
        edge_gap();
        edge_gap();
        check(gap, per);
        // Interrupt line registers one cycle after the flag
        idle(1);
        check(irq, 7'h02);
        xfer(gts_pkg::STATUS_OFFSET, 1'b0, 32'h0);
        check(q & 32'h11, 32'h11);
        xfer(gts_pkg::CTRL_OFFSET, 1'b1, c);
        xfer(gts_pkg::STATUS_OFFSET, 1'b1, 32'h7);
        xfer(gts_pkg::STATUS_OFFSET, 1'b0, 32'h0);
        check(q & 32'h17, 32'h0);
        check(irq, 7'h00);
    endtask : square_scn

    // Capture mode: a gate negation freezes the shadow until cleared
    task automatic capture_scn();
        xfer(gts_pkg::PRELOAD1_OFFSET, 1'b1, 32'h40);
        // Compare written before the count starts, never at a match
        xfer(gts_pkg::COMPARE_OFFSET, 1'b1, 32'h3E);
        xfer(gts_pkg::CTRL_OFFSET, 1'b1, 32'h1D006);
        xfer(gts_pkg::CTRL_OFFSET, 1'b1, 32'h1D007);
        idle(20);
        gate_on <= 1'b0;
        idle(6);
        xfer(gts_pkg::SHADOW_OFFSET, 1'b0, 32'h0);
        q2 = q;
        idle(8);
        xfer(gts_pkg::SHADOW_OFFSET, 1'b0, 32'h0);
        check(q, q2);
        xfer(gts_pkg::STATUS_OFFSET, 1'b0, 32'h0);
        check(q & 32'h42, 32'h02);
        check(q & 32'h0C, 32'h0C);
        check(irq, 7'h40);
        gate_on <= 1'b1;
        xfer(gts_pkg::STATUS_OFFSET, 1'b1, 32'h2);
        xfer(gts_pkg::SHADOW_OFFSET, 1'b0, 32'h0);
        q2 = q;
        idle(8);
        xfer(gts_pkg::SHADOW_OFFSET, 1'b0, 32'h0);
        check(q !== q2, 1'b1);
        xfer(gts_pkg::CTRL_OFFSET, 1'b1, 32'h1D006);
        xfer(gts_pkg::STATUS_OFFSET, 1'b1, 32'h7);
    endtask : capture_scn

    // Square mode with the gate controlling the count
    task automatic gate_sq_scn();
        xfer(gts_pkg::PRELOAD1_OFFSET, 1'b1, 32'h40);
        xfer(gts_pkg::CTRL_OFFSET, 1'b1, 32'h26);
        xfer(gts_pkg::CTRL_OFFSET, 1'b1, 32'h27);
        idle(6);
        xfer(gts_pkg::STATUS_OFFSET, 1'b0, 32'h0);
        check(q & 32'h12, 32'h10);
        gate_on <= 1'b0;
        idle(6);
        xfer(gts_pkg::STATUS_OFFSET, 1'b0, 32'h0);
        check(q & 32'h12, 32'h02);
        gate_on <= 1'b1;
        idle(6);
        xfer(gts_pkg::STATUS_OFFSET, 1'b0, 32'h0);
        check(q & 32'h12, 32'h12);
        xfer(gts_pkg::CTRL_OFFSET, 1'b1, 32'h26);
    endtask : gate_sq_scn

    task automatic finish_test();
        $display("mismatches %0d of %0d comparisons", miscompares, n_tests);
        if (miscompares == 0 && n_tests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : finish_test

    initial begin
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        reset_scn();
        square_scn(1'b0, 8);
        square_scn(1'b1, 24);
        capture_scn();
        gate_sq_scn();
        finish_test();
    end

    // The whole run needs well under a few thousand cycles
    initial begin
        repeat (20000) @(posedge clk);
        miscompares++;
        finish_test();
    end
endmodule : testbench
